// ==== src/cx_exec.sv ====
// execution unit for branches, bit ops, shifts, flag ops and data transfer
`timescale 1ns/1ps
// What this block does
// RQ1 - branch on T clear, V set/clear
// RQ2 - branch on interrupt enable set or clear
// RQ3 - io bit set/clear, two cycles, 0x00-0x1F
// RQ4 - io bit ops write only named bit
// RQ5 - skip on io bit set or clear
// RQ6 - left shift, rotate, nibble swap, one cycle
// RQ7 - right shifts and rotate update Z,C,N,V
// RQ8 - set or clear one status flag
// RQ9 - copy bit to and from T flag
// RQ10 - indirect loads, post-inc, pre-dec, two cycles
// RQ11 - indirect stores, post-inc, pre-dec, two cycles
// RQ12 - displacement access, pointer unchanged, two cycles
// RQ13 - direct load and store, two cycles
// RQ14 - program memory load, three cycles, R0 default
// RQ15 - push and pop, two cycles each
// RQ16 - port in/out, one cycle, 0x00-0x3F
// RQ17 - io seen in data space at +0x20
// RQ18 - extended io only by load/store
// RQ19 - software zeroes reserved bits, skips reserved
// RQ20 - nop, sleep, watchdog restart take one cycle
// RQ21 - branch one cycle not taken, two taken
// RQ22 - break is nop without debugger attached
module cx_exec #(
  parameter logic [15:0] SP_INIT = cx_pkg::SP_RESET
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire cx_pkg::cx_instr_type instr_i,
  output logic instr_ready_o,
  output cx_pkg::cx_mem_req_type mem_req_o,
  input wire logic [15:0] mem_rdata_i,
  output logic [15:0] pc_o,
  output logic [7:0] flags_o,
  output logic sleep_o,
  output logic wdr_o,
  output logic break_o,
  input wire cx_pkg::cx_wb_req_type wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  cx_pkg::cx_core_type q;
  cx_pkg::cx_core_type d;
  cx_pkg::cx_mem_req_type mreq;
  logic take;
  logic wr;
  logic resume;
  logic [7:0] rdv;
  logic [7:0] rrv;
  logic [7:0] res;
  logic cy;
  logic [4:0] pidx;
  logic [15:0] ptr;
  logic [15:0] nptr;
  logic [15:0] br_target;
  logic cond;

  // ==========================================================
  // next state
  always_comb
  begin
    d = q;
    mreq = '0;
    sleep_o = 1'b0;
    wdr_o = 1'b0;
    break_o = 1'b0;
    res = 8'h00;
    cy = 1'b0;
    cond = 1'b0;
    take = instr_valid_i && (q.st == cx_pkg::ST_IDLE);
    rdv = q.regs[instr_i.rd];
    rrv = q.regs[instr_i.rr];
    case (instr_i.ptr)
      cx_pkg::PTR_X: pidx = cx_pkg::REG_X_LO;
      cx_pkg::PTR_Y: pidx = cx_pkg::REG_Y_LO;
      default: pidx = cx_pkg::REG_Z_LO;
    endcase
    if (instr_i.op == cx_pkg::OP_LPM)
      pidx = cx_pkg::REG_Z_LO;
    ptr = {q.regs[pidx + 5'h01], q.regs[pidx]};
    nptr = ptr;
    br_target = q.pc + 16'h0001 + {{9{instr_i.imm[6]}}, instr_i.imm[6:0]};
    // bus slave, one wait state, every address answers
    d.ack = wb_i.cyc && wb_i.stb && !q.ack;
    wr = q.ack && wb_i.cyc && wb_i.stb && wb_i.we;
    resume = 1'b0;
    d.wb_dat = 32'h0000_0000;
    if (wb_i.adr[cx_pkg::REGWIN_BIT])
    begin
      d.wb_dat[7:0] = q.regs[wb_i.adr[6:2]];
      if (wr && wb_i.sel[0])
        d.regs[wb_i.adr[6:2]] = wb_i.dat[7:0];
    end
    else
    begin
      case (wb_i.adr)
        cx_pkg::OFS_CTRL:
        begin
          d.wb_dat[cx_pkg::CTRL_DBG] = q.dbg_en;
          if (wr && wb_i.sel[0])
          begin
            d.dbg_en = wb_i.dat[cx_pkg::CTRL_DBG];
            resume = wb_i.dat[cx_pkg::CTRL_RESUME];
          end
        end
        cx_pkg::OFS_STATUS:
        begin
          d.wb_dat[7:0] = q.flags;
          d.wb_dat[cx_pkg::STAT_HALT] = (q.st == cx_pkg::ST_HALT);
          d.wb_dat[cx_pkg::STAT_ILLEGAL] = q.illegal;
          if (wr && wb_i.sel[1] && wb_i.dat[cx_pkg::STAT_ILLEGAL])
            d.illegal = 1'b0;
        end
        cx_pkg::OFS_PC: d.wb_dat[15:0] = q.pc;
        cx_pkg::OFS_SP:
        begin
          d.wb_dat[15:0] = q.sp;
          if (wr && wb_i.sel[0])
            d.sp[7:0] = wb_i.dat[7:0];
          if (wr && wb_i.sel[1])
            d.sp[15:8] = wb_i.dat[15:8];
        end
        default: d.wb_dat = 32'h0000_0000;
      endcase
    end
    // core sequencing; hardware updates override the bus
    case (q.st)
      cx_pkg::ST_IDLE:
      begin
        if (take)
        begin
          d.ins = instr_i;
          d.pc = q.pc + 16'h0001;
          case (instr_i.op)
            cx_pkg::OP_SLEEP: sleep_o = 1'b1; // RQ20
            cx_pkg::OP_WDR: wdr_o = 1'b1; // RQ20
            cx_pkg::OP_BREAK:
            begin
              // without a debugger it falls through as a nop
              if (q.dbg_en) // RQ22
              begin
                break_o = 1'b1;
                d.st = cx_pkg::ST_HALT;
              end
            end
            cx_pkg::OP_BR_TCLR, cx_pkg::OP_BR_VSET, cx_pkg::OP_BR_VCLR,
            cx_pkg::OP_BR_IEN, cx_pkg::OP_BR_IDIS:
            begin
              case (instr_i.op)
                cx_pkg::OP_BR_TCLR: cond = !q.flags[cx_pkg::FLAG_T]; // RQ1
                cx_pkg::OP_BR_VSET: cond = q.flags[cx_pkg::FLAG_V]; // RQ1
                cx_pkg::OP_BR_VCLR: cond = !q.flags[cx_pkg::FLAG_V]; // RQ1
                cx_pkg::OP_BR_IEN: cond = q.flags[cx_pkg::FLAG_I]; // RQ2
                default: cond = !q.flags[cx_pkg::FLAG_I]; // RQ2
              endcase
              if (cond) // RQ21
              begin
                d.pc = br_target;
                d.st = cx_pkg::ST_ACCESS;
              end
            end
            cx_pkg::OP_IO_SET, cx_pkg::OP_IO_CLR, cx_pkg::OP_SKIP_SET, cx_pkg::OP_SKIP_CLR:
            begin
              // out-of-window address is dropped and flagged
              if (instr_i.ioa > cx_pkg::IO_BIT_MAX) // RQ3
                d.illegal = 1'b1;
              else
              begin
                d.addr = {10'h000, instr_i.ioa} + cx_pkg::IO_DATA_OFS; // RQ17
                d.st = cx_pkg::ST_ACCESS; // RQ5
              end
            end
            cx_pkg::OP_LSL, cx_pkg::OP_LSR, cx_pkg::OP_ROL, cx_pkg::OP_ROR, cx_pkg::OP_ASR:
            begin
              case (instr_i.op)
                cx_pkg::OP_LSL: {cy, res} = {rdv, 1'b0}; // RQ6
                cx_pkg::OP_ROL: {cy, res} = {rdv, q.flags[cx_pkg::FLAG_C]}; // RQ6
                cx_pkg::OP_LSR: {res, cy} = {1'b0, rdv}; // RQ7
                cx_pkg::OP_ROR: {res, cy} = {q.flags[cx_pkg::FLAG_C], rdv}; // RQ7
                default: {res, cy} = {rdv[7], rdv}; // RQ7
              endcase
              d.regs[instr_i.rd] = res;
              d.flags[cx_pkg::FLAG_C] = cy;
              d.flags[cx_pkg::FLAG_N] = res[7];
              d.flags[cx_pkg::FLAG_V] = res[7] ^ cy;
              d.flags[cx_pkg::FLAG_Z] = (res == 8'h00);
            end
            cx_pkg::OP_SWAP: d.regs[instr_i.rd] = {rdv[3:0], rdv[7:4]}; // RQ6
            cx_pkg::OP_FSET: d.flags[instr_i.bsel] = 1'b1; // RQ8
            cx_pkg::OP_FCLR: d.flags[instr_i.bsel] = 1'b0; // RQ8
            cx_pkg::OP_BST: d.flags[cx_pkg::FLAG_T] = rrv[instr_i.bsel]; // RQ9
            cx_pkg::OP_BLD: d.regs[instr_i.rd][instr_i.bsel] = q.flags[cx_pkg::FLAG_T]; // RQ9
            cx_pkg::OP_LD_IND, cx_pkg::OP_ST_IND:
            begin
              d.addr = ptr;
              if (instr_i.mode == cx_pkg::MODE_PRE) // RQ10 RQ11
              begin
                nptr = ptr - 16'h0001;
                d.addr = nptr;
              end
              else if (instr_i.mode == cx_pkg::MODE_POST) // RQ10 RQ11
                nptr = ptr + 16'h0001;
              d.regs[pidx] = nptr[7:0];
              d.regs[pidx + 5'h01] = nptr[15:8];
              d.st = cx_pkg::ST_ACCESS;
            end
            cx_pkg::OP_LD_DISP, cx_pkg::OP_ST_DISP:
            begin
              d.addr = ptr + {10'h000, instr_i.imm[5:0]}; // RQ12
              d.st = cx_pkg::ST_ACCESS;
            end
            cx_pkg::OP_LDS, cx_pkg::OP_STS:
            begin
              // address word follows the opcode
              d.addr = instr_i.imm; // RQ13
              d.pc = q.pc + 16'h0002;
              d.st = cx_pkg::ST_ACCESS;
            end
            cx_pkg::OP_LPM:
            begin
              d.addr = ptr; // RQ14
              if (instr_i.mode == cx_pkg::MODE_POST)
              begin
                nptr = ptr + 16'h0001;
                d.regs[pidx] = nptr[7:0];
                d.regs[pidx + 5'h01] = nptr[15:8];
              end
              d.st = cx_pkg::ST_ACCESS;
            end
            cx_pkg::OP_PUSH:
            begin
              d.addr = q.sp; // RQ15
              d.sp = q.sp - 16'h0001;
              d.st = cx_pkg::ST_ACCESS;
            end
            cx_pkg::OP_POP:
            begin
              d.addr = q.sp + 16'h0001; // RQ15
              d.sp = q.sp + 16'h0001;
              d.st = cx_pkg::ST_ACCESS;
            end
            cx_pkg::OP_IN, cx_pkg::OP_OUT:
            begin
              // six-bit port number cannot reach the extended window
              mreq.req = 1'b1; // RQ16 RQ18
              mreq.addr = {10'h000, instr_i.ioa} + cx_pkg::IO_DATA_OFS; // RQ17
              if (instr_i.op == cx_pkg::OP_OUT)
              begin
                mreq.we = 1'b1;
                mreq.wdata = rrv;
                mreq.wmask = 8'hFF;
              end
              else
                d.regs[instr_i.rd] = mem_rdata_i[7:0];
            end
            default: d.st = cx_pkg::ST_IDLE; // RQ20
          endcase
          // store data is frozen before any pointer update lands
          d.wdat = rrv;
        end
      end
      cx_pkg::ST_ACCESS:
      begin
        d.st = cx_pkg::ST_IDLE;
        mreq.addr = q.addr;
        case (q.ins.op)
          cx_pkg::OP_IO_SET, cx_pkg::OP_IO_CLR:
          begin
            // no read-modify-write: write-one-to-clear neighbours stay intact
            mreq.req = 1'b1; // RQ3
            mreq.we = 1'b1;
            mreq.wmask = 8'h01 << q.ins.bsel; // RQ4
            mreq.wdata = (q.ins.op == cx_pkg::OP_IO_SET) ? mreq.wmask : 8'h00;
          end
          cx_pkg::OP_SKIP_SET, cx_pkg::OP_SKIP_CLR:
          begin
            mreq.req = 1'b1;
            if (mem_rdata_i[q.ins.bsel] == (q.ins.op == cx_pkg::OP_SKIP_SET)) // RQ5
              d.pc = q.pc + 16'h0001;
          end
          cx_pkg::OP_LD_IND, cx_pkg::OP_LD_DISP, cx_pkg::OP_LDS, cx_pkg::OP_POP:
          begin
            mreq.req = 1'b1; // RQ10 RQ12 RQ13 RQ15
            d.regs[q.ins.rd] = mem_rdata_i[7:0];
          end
          cx_pkg::OP_ST_IND, cx_pkg::OP_ST_DISP, cx_pkg::OP_STS, cx_pkg::OP_PUSH:
          begin
            mreq.req = 1'b1; // RQ11 RQ12 RQ13 RQ15
            mreq.we = 1'b1;
            mreq.wdata = q.wdat;
            mreq.wmask = 8'hFF;
          end
          cx_pkg::OP_LPM:
          begin
            mreq.req = 1'b1;
            mreq.prog = 1'b1;
            d.st = cx_pkg::ST_WAIT; // RQ14
          end
          default: d.st = cx_pkg::ST_IDLE; // RQ21
        endcase
      end
      cx_pkg::ST_WAIT:
      begin
        // program memory holds words; pointer bit 0 picks the byte
        mreq.req = 1'b1;
        mreq.prog = 1'b1;
        mreq.addr = q.addr;
        res = q.addr[0] ? mem_rdata_i[15:8] : mem_rdata_i[7:0];
        if (q.ins.mode == cx_pkg::MODE_IMPL)
          d.regs[cx_pkg::REG_R0] = res; // RQ14
        else
          d.regs[q.ins.rd] = res;
        d.st = cx_pkg::ST_IDLE;
      end
      cx_pkg::ST_HALT:
      begin
        if (resume)
          d.st = cx_pkg::ST_IDLE;
      end
      default: d.st = cx_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.st <= cx_pkg::ST_IDLE;
      q.sp <= SP_INIT;
    end
    else
      q <= d;
  end

  assign instr_ready_o = (q.st == cx_pkg::ST_IDLE);
  assign mem_req_o = mreq;
  assign pc_o = q.pc;
  assign flags_o = q.flags;
  assign wb_dat_o = q.wb_dat;
  assign wb_ack_o = q.ack;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_branch_taken_pc: assert property ( // RQ1
    take && instr_i.op == cx_pkg::OP_BR_VSET && q.flags[cx_pkg::FLAG_V]
    |=> !instr_ready_o ##1 (instr_ready_o && pc_o == $past(br_target, 2)))
    else $error("taken branch target or timing wrong");
  a_branch_irq_fall: assert property ( // RQ21
    take && instr_i.op == cx_pkg::OP_BR_IEN && !q.flags[cx_pkg::FLAG_I]
    |=> instr_ready_o && pc_o == $past(pc_o) + 16'h0001)
    else $error("untaken branch not sequential in one cycle");
  a_iobit_one_hot: assert property ( // RQ4
    take && instr_i.op == cx_pkg::OP_IO_SET && instr_i.ioa <= cx_pkg::IO_BIT_MAX
    |=> mem_req_o.req && mem_req_o.we && $onehot(mem_req_o.wmask)
        && mem_req_o.wdata == mem_req_o.wmask
        && mem_req_o.addr == {10'h000, $past(instr_i.ioa)} + cx_pkg::IO_DATA_OFS)
    else $error("io bit set write is not a single bit");
  a_iobit_range: assert property ( // RQ3
    take && instr_i.op inside {cx_pkg::OP_IO_SET, cx_pkg::OP_IO_CLR} && instr_i.ioa > cx_pkg::IO_BIT_MAX
    |=> !mem_req_o.req && q.illegal && instr_ready_o)
    else $error("io bit op outside window not refused");
  a_shift_left_carry: assert property ( // RQ6
    take && instr_i.op == cx_pkg::OP_LSL
    |=> flags_o[cx_pkg::FLAG_C] == $past(rdv[7])
        && flags_o[cx_pkg::FLAG_Z] == ($past(rdv[6:0]) == 7'h00))
    else $error("left shift flags wrong");
  a_rotate_right: assert property ( // RQ7
    take && instr_i.op == cx_pkg::OP_ROR
    |=> flags_o[cx_pkg::FLAG_C] == $past(rdv[0])
        && flags_o[cx_pkg::FLAG_N] == $past(q.flags[cx_pkg::FLAG_C]))
    else $error("rotate right flags wrong");
  a_flag_set_only: assert property ( // RQ8
    take && instr_i.op == cx_pkg::OP_FSET
    |=> flags_o == ($past(q.flags) | (8'h01 << $past(instr_i.bsel))))
    else $error("flag set touched other flags");
  a_load_two_cyc: assert property ( // RQ10
    take && instr_i.op == cx_pkg::OP_LD_IND
    |=> (!instr_ready_o && mem_req_o.req && !mem_req_o.we) ##1 instr_ready_o)
    else $error("indirect load not two cycles");
  a_lpm_three_cyc: assert property ( // RQ14
    take && instr_i.op == cx_pkg::OP_LPM
    |=> (mem_req_o.req && mem_req_o.prog) [*2] ##1 instr_ready_o)
    else $error("program load not three cycles");
  a_port_window: assert property ( // RQ18
    mem_req_o.req && !mem_req_o.prog && q.st == cx_pkg::ST_IDLE
    |-> mem_req_o.addr >= cx_pkg::IO_DATA_OFS && mem_req_o.addr <= cx_pkg::IO_PORT_LAST)
    else $error("port access outside io window");
  a_push_stack: assert property ( // RQ15
    take && instr_i.op == cx_pkg::OP_PUSH
    |=> q.sp == $past(q.sp) - 16'h0001 && mem_req_o.we && mem_req_o.addr == $past(q.sp))
    else $error("push address or stack pointer wrong");

  c_branch_taken: cover property (take && instr_i.op == cx_pkg::OP_BR_TCLR ##1 !instr_ready_o);
  c_lpm_done: cover property (q.st == cx_pkg::ST_WAIT ##1 instr_ready_o);
  c_break_halt: cover property (break_o ##1 q.st == cx_pkg::ST_HALT);
  c_io_out: cover property (take && instr_i.op == cx_pkg::OP_OUT);
endmodule

// ==== src/cx_pkg.sv ====
// shared types and constants of the instruction subset execution unit
package cx_pkg;
  // ==========================================================
  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  // ==========================================================
  // register file and address windows
  localparam logic [4:0] REG_R0 = 5'h00;
  localparam logic [4:0] REG_X_LO = 5'h1A;
  localparam logic [4:0] REG_Y_LO = 5'h1C;
  localparam logic [4:0] REG_Z_LO = 5'h1E;
  localparam logic [5:0] IO_BIT_MAX = 6'h1F;
  localparam logic [15:0] IO_DATA_OFS = 16'h0020;
  localparam logic [15:0] IO_PORT_LAST = 16'h005F;
  localparam logic [15:0] SP_RESET = 16'h0000;
  // ==========================================================
  // bus register offsets and fields
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_SP = 8'h0C;
  localparam int REGWIN_BIT = 7;
  localparam int CTRL_DBG = 0;
  localparam int CTRL_RESUME = 1;
  localparam int STAT_HALT = 8;
  localparam int STAT_ILLEGAL = 9;
  // ==========================================================
  // pointer select and addressing mode
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_POST = 2'h1;
  localparam logic [1:0] MODE_PRE = 2'h2;
  localparam logic [1:0] MODE_IMPL = 2'h3;

  typedef enum logic [5:0] {
    OP_NOP, OP_SLEEP, OP_WDR, OP_BREAK,
    OP_BR_TCLR, OP_BR_VSET, OP_BR_VCLR, OP_BR_IEN, OP_BR_IDIS,
    OP_IO_SET, OP_IO_CLR, OP_SKIP_SET, OP_SKIP_CLR,
    OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR, OP_SWAP,
    OP_FSET, OP_FCLR, OP_BST, OP_BLD,
    OP_LD_IND, OP_ST_IND, OP_LD_DISP, OP_ST_DISP, OP_LDS, OP_STS,
    OP_LPM, OP_IN, OP_OUT, OP_PUSH, OP_POP
  } cx_op_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACCESS = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_HALT = 4'b1000
  } cx_state_type;

  typedef struct packed {
    cx_op_type op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bsel;
    logic [1:0] ptr;
    logic [1:0] mode;
    logic [5:0] ioa;
    logic [15:0] imm;
  } cx_instr_type;

  typedef struct packed {
    logic req;
    logic we;
    logic prog;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
  } cx_mem_req_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } cx_wb_req_type;

  typedef struct packed {
    logic [31:0][7:0] regs;
    logic [7:0] flags;
    logic [15:0] pc;
    logic [15:0] sp;
    cx_state_type st;
    cx_instr_type ins;
    logic [15:0] addr;
    logic [7:0] wdat;
    logic dbg_en;
    logic illegal;
    logic ack;
    logic [31:0] wb_dat;
  } cx_core_type;
endpackage

// ==== tb/cx_exec_test.sv ====
// self-checking bench for the instruction subset execution unit
`timescale 1ns/1ps
module cx_exec_test;
  typedef struct packed {
    cx_pkg::cx_op_type op;
    logic [7:0] a;
    logic c;
    logic [7:0] r;
    logic co;
  } cx_row_type;
  localparam cx_row_type ROWS [7] = '{
    '{cx_pkg::OP_LSL, 8'h81, 1'h0, 8'h02, 1'h1},
    '{cx_pkg::OP_ROL, 8'h81, 1'h1, 8'h03, 1'h1},
    '{cx_pkg::OP_ROL, 8'h00, 1'h0, 8'h00, 1'h0},
    '{cx_pkg::OP_LSR, 8'h81, 1'h0, 8'h40, 1'h1},
    '{cx_pkg::OP_ROR, 8'h01, 1'h1, 8'h80, 1'h1},
    '{cx_pkg::OP_ASR, 8'h82, 1'h0, 8'hC1, 1'h0},
    '{cx_pkg::OP_SWAP, 8'h3C, 1'h1, 8'hC3, 1'h1}
  };
  localparam cx_pkg::cx_op_type BOPS [5] = '{cx_pkg::OP_BR_TCLR, cx_pkg::OP_BR_VSET, cx_pkg::OP_BR_VCLR,
    cx_pkg::OP_BR_IEN, cx_pkg::OP_BR_IDIS};
  localparam int SETF [3] = '{cx_pkg::FLAG_T, cx_pkg::FLAG_V, cx_pkg::FLAG_I};
  localparam cx_pkg::cx_op_type MOPS [4] = '{cx_pkg::OP_NOP, cx_pkg::OP_SLEEP, cx_pkg::OP_WDR, cx_pkg::OP_BREAK};
  localparam logic [2:0] PULSE [4] = '{3'h0, 3'h4, 3'h2, 3'h0};
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic instr_valid_i = 1'h0;
  cx_pkg::cx_instr_type instr_i = '0;
  cx_pkg::cx_wb_req_type wb_i = '0;
  cx_pkg::cx_mem_req_type mem_req_o;
  logic instr_ready_o, sleep_o, wdr_o, break_o, wb_ack_o, slp, wdg, brk, tk;
  logic [15:0] mem_rdata_i, pc_o, epc;
  logic [7:0] flags_o;
  logic [31:0] wb_dat_o, rdat;
  int fail_count = 0;
  int n_tests = 0;
  int ncyc;
  always #2 clk_i = ~clk_i;
  cx_exec dut (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .instr_ready_o(instr_ready_o), .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i), .pc_o(pc_o),
    .flags_o(flags_o), .sleep_o(sleep_o), .wdr_o(wdr_o), .break_o(break_o), .wb_i(wb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  cx_mem_model mdl (.clk_i(clk_i), .req_i(mem_req_o), .rdata_o(mem_rdata_i));
  // ==========================================================
  // compare and bus tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_cyc(input int got, input int exp);
    n_tests++;
    if (got != exp)
    begin
      fail_count++;
      $display("BAD t=%0t took %0d cycles want %0d", $time, got, exp);
    end
  endtask
  function automatic cx_pkg::cx_instr_type mk(input cx_pkg::cx_op_type op, input logic [4:0] r,
      input logic [2:0] b = 3'h0, input logic [3:0] pm = 4'h0, input logic [15:0] k = 16'h0, input logic [5:0] io = 6'h0);
    mk = '{op: op, rd: r, rr: r, bsel: b, ptr: pm[3:2], mode: pm[1:0], ioa: io, imm: k};
  endfunction
  // master holds the whole request until the edge that samples ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'h1, stb: 1'h1, we: w, adr: a, sel: s, dat: d};
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'h1)
        break;
    end
    if (i == 20)
      chk(16'h0, 16'h1);
    rdat = wb_dat_o;
    wb_i <= '0;
  endtask
  task automatic putr(input logic [4:0] n, input logic [7:0] d);
    wb(1'h1, {1'h1, n, 2'h0}, {24'h0, d}, 4'hF);
  endtask
  task automatic getr(input logic [4:0] n, input logic [7:0] e);
    wb(1'h0, {1'h1, n, 2'h0}, 32'h0, 4'hF);
    chk({8'h0, rdat[7:0]}, {8'h0, e});
  endtask
  task automatic putw(input logic [4:0] n, input logic [15:0] d);
    putr(n, d[7:0]);
    putr(n + 5'h1, d[15:8]);
  endtask
  task automatic getw(input logic [4:0] n, input logic [15:0] e);
    getr(n, e[7:0]);
    getr(n + 5'h1, e[15:8]);
  endtask
  // cycles counted from the take edge until ready returns
  task automatic run(input cx_pkg::cx_instr_type ins, input int cyc, input int dpc);
    int i;
    @(posedge clk_i);
    instr_valid_i <= 1'h1;
    instr_i <= ins;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_i);
      if (instr_ready_o === 1'h1)
        break;
    end
    slp = sleep_o;
    wdg = wdr_o;
    brk = break_o;
    instr_valid_i <= 1'h0;
    ncyc = 1;
    @(negedge clk_i);
    while (instr_ready_o !== 1'h1 && ncyc < 20)
    begin
      ncyc++;
      @(negedge clk_i);
    end
    epc = epc + 16'(dpc);
    chk_cyc(ncyc, cyc);
    chk(pc_o, epc);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    conclude();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    epc = 16'h0;
    mdl.dmem[16'h0100] = 8'h5A;
    mdl.dmem[16'h0160] = 8'h3C;
    mdl.dmem[16'h023E] = 8'hC7;
    mdl.dmem[16'h0020] = 8'h77;
    mdl.dmem[16'h003F] = 8'h80;
    mdl.dmem[16'h0040] = 8'h00;
    mdl.pmem[10'h180] = 16'h1234;
    mdl.pmem[10'h181] = 16'h0056;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    chk(pc_o, 16'h0);
    chk({8'h0, flags_o}, 16'h0);
    wb(1'h0, cx_pkg::OFS_SP, 32'h0, 4'hF);
    chk(rdat[15:0], 16'h0);
    wb(1'h1, 8'h40, 32'hFF, 4'hF);
    wb(1'h0, 8'h40, 32'h0, 4'hF);
    chk(rdat[15:0], 16'h0);
    for (int i = 0; i < 8; i++)
    begin
      run(mk(cx_pkg::OP_FSET, 5'h0, 3'(i)), 1, 1);
      chk({8'h0, flags_o}, 16'((1 << (i + 1)) - 1));
    end
    for (int i = 0; i < 8; i++)
    begin
      run(mk(cx_pkg::OP_FCLR, 5'h0, 3'(i)), 1, 1);
      chk({8'h0, flags_o}, {8'h0, 8'(8'hFF << (i + 1))});
    end
    foreach (ROWS[j])
    begin
      putr(5'h5, ROWS[j].a);
      run(mk(ROWS[j].c ? cx_pkg::OP_FSET : cx_pkg::OP_FCLR, 5'h0, 3'(cx_pkg::FLAG_C)), 1, 1);
      run(mk(ROWS[j].op, 5'h5), 1, 1);
      getr(5'h5, ROWS[j].r);
      chk(16'(flags_o[cx_pkg::FLAG_C]), 16'(ROWS[j].co));
      if (ROWS[j].op != cx_pkg::OP_SWAP)
      begin
        chk(16'(flags_o[cx_pkg::FLAG_Z]), 16'(ROWS[j].r == 8'h0));
        chk(16'(flags_o[cx_pkg::FLAG_N]), 16'(ROWS[j].r[7]));
      end
    end
    // second pass flips every condition, backwards offset
    for (int p = 0; p < 2; p++)
    begin
      foreach (SETF[f])
        run(mk(p ? cx_pkg::OP_FSET : cx_pkg::OP_FCLR, 5'h0, 3'(SETF[f])), 1, 1);
      for (int j = 0; j < 5; j++)
      begin
        tk = ((j % 2) == 0) ^ (p == 1);
        run(mk(BOPS[j], 5'h0, 3'h0, 4'h0, p ? 16'hFFFD : 16'h0005), tk ? 2 : 1, tk ? (p ? -2 : 6) : 1);
      end
    end
    putr(5'h3, 8'h10);
    run(mk(cx_pkg::OP_BST, 5'h3, 3'h3), 1, 1);
    chk(16'(flags_o[cx_pkg::FLAG_T]), 16'h0);
    run(mk(cx_pkg::OP_BST, 5'h3, 3'h4), 1, 1);
    chk(16'(flags_o[cx_pkg::FLAG_T]), 16'h1);
    run(mk(cx_pkg::OP_BLD, 5'h3, 3'h0), 1, 1);
    getr(5'h3, 8'h11);
    putw(5'h1A, 16'h0100);
    putw(5'h1C, 16'h0200);
    putw(5'h1E, 16'h0300);
    run(mk(cx_pkg::OP_LD_IND, 5'h2, 3'h0, 4'h1), 2, 1);
    getr(5'h2, 8'h5A);
    getw(5'h1A, 16'h0101);
    run(mk(cx_pkg::OP_ST_IND, 5'h2, 3'h0, 4'h6), 2, 1);
    chk({8'h0, mdl.dmem[16'h01FF]}, 16'h005A);
    getw(5'h1C, 16'h01FF);
    run(mk(cx_pkg::OP_ST_DISP, 5'h2, 3'h0, 4'h8, 16'h003F), 2, 1);
    chk({8'h0, mdl.dmem[16'h033F]}, 16'h005A);
    getw(5'h1E, 16'h0300);
    run(mk(cx_pkg::OP_LD_DISP, 5'h4, 3'h0, 4'h4, 16'h003F), 2, 1);
    getr(5'h4, 8'hC7);
    getw(5'h1C, 16'h01FF);
    run(mk(cx_pkg::OP_LDS, 5'h6, 3'h0, 4'h0, 16'h0160), 2, 2);
    getr(5'h6, 8'h3C);
    run(mk(cx_pkg::OP_STS, 5'h6, 3'h0, 4'h0, 16'h00DD), 2, 2);
    chk({8'h0, mdl.dmem[16'h00DD]}, 16'h003C);
    putw(5'h1E, 16'h0301);
    run(mk(cx_pkg::OP_LPM, 5'h7, 3'h0, 4'h9), 3, 1);
    getr(5'h7, 8'h12);
    getw(5'h1E, 16'h0302);
    run(mk(cx_pkg::OP_LPM, 5'h7, 3'h0, 4'hB), 3, 1);
    getr(5'h0, 8'h56);
    wb(1'h1, cx_pkg::OFS_SP, 32'h0400, 4'hF);
    run(mk(cx_pkg::OP_PUSH, 5'h2), 2, 1);
    chk({8'h0, mdl.dmem[16'h0400]}, 16'h005A);
    run(mk(cx_pkg::OP_POP, 5'h8), 2, 1);
    getr(5'h8, 8'h5A);
    wb(1'h0, cx_pkg::OFS_SP, 32'h0, 4'hF);
    chk(rdat[15:0], 16'h0400);
    run(mk(cx_pkg::OP_OUT, 5'h2, 3'h0, 4'h0, 16'h0, 6'h3F), 1, 1);
    chk({8'h0, mdl.dmem[16'h005F]}, 16'h005A);
    run(mk(cx_pkg::OP_IN, 5'h9, 3'h0, 4'h0, 16'h0, 6'h00), 1, 1);
    getr(5'h9, 8'h77);
    run(mk(cx_pkg::OP_IO_SET, 5'h0, 3'h3, 4'h0, 16'h0, 6'h1F), 2, 1);
    chk({8'h0, mdl.dmem[16'h003F]}, 16'h0088);
    run(mk(cx_pkg::OP_IO_CLR, 5'h0, 3'h4, 4'h0, 16'h0, 6'h00), 2, 1);
    chk({8'h0, mdl.dmem[16'h0020]}, 16'h0067);
    run(mk(cx_pkg::OP_SKIP_SET, 5'h0, 3'h3, 4'h0, 16'h0, 6'h1F), 2, 2);
    run(mk(cx_pkg::OP_SKIP_CLR, 5'h0, 3'h3, 4'h0, 16'h0, 6'h1F), 2, 1);
    // refused: bit ops above the low window write nothing and set illegal
    run(mk(cx_pkg::OP_IO_SET, 5'h0, 3'h0, 4'h0, 16'h0, 6'h20), 1, 1);
    chk({8'h0, mdl.dmem[16'h0040]}, 16'h0000);
    wb(1'h0, cx_pkg::OFS_STATUS, 32'h0, 4'hF);
    chk(16'(rdat[cx_pkg::STAT_ILLEGAL]), 16'h1);
    wb(1'h1, cx_pkg::OFS_STATUS, 32'h0200, 4'h2);
    wb(1'h0, cx_pkg::OFS_STATUS, 32'h0, 4'hF);
    chk(16'(rdat[cx_pkg::STAT_ILLEGAL]), 16'h0);
    foreach (MOPS[j])
    begin
      run(mk(MOPS[j], 5'h0), 1, 1);
      chk(16'({slp, wdg, brk}), 16'(PULSE[j]));
    end
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    chk(pc_o, 16'h0);
    conclude();
  end
endmodule

// ==== tb/cx_mem_model.sv ====
// data and program memory model on the far side of the execution unit
`timescale 1ns/1ps
module cx_mem_model (
  input wire logic clk_i,
  input wire cx_pkg::cx_mem_req_type req_i,
  output logic [15:0] rdata_o
);
  logic [7:0] dmem [0:65535];
  logic [15:0] pmem [0:1023];
  logic [15:0] junk_q = 16'hA5A5;
  // ==========================================================
  // write side
  // merge under mask so a one-bit io write leaves its neighbours alone
  always @(posedge clk_i)
  begin
    junk_q <= ~junk_q;
    if (req_i.req && req_i.we && !req_i.prog)
    begin
      dmem[req_i.addr] <= (dmem[req_i.addr] & ~req_i.wmask) | (req_i.wdata & req_i.wmask);
    end
  end
  // ==========================================================
  // read side
  // idle bus toggles so a stale value is never mistaken for data
  always_comb
  begin
    if (!req_i.req)
      rdata_o = junk_q;
    else if (req_i.prog)
      rdata_o = pmem[req_i.addr[10:1]];
    else
      rdata_o = {8'h00, dmem[req_i.addr]};
  end
endmodule
